/* shared/rsic_pkg.sv */
package rsic_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [4:0] RANGE_MAX = 5'h1F;
  localparam logic [4:0] RANGE_DEF = 5'h1F;
  localparam logic [3:0] ATTEN_MAX = 4'hA;
  localparam logic [3:0] ATTEN_DEF = 4'h0;
  localparam logic [8:0] FREQ_MAX = 9'h118;
  localparam logic [19:0] FREQ_BASE_KHZ = 20'hD_1F60;
  localparam logic [10:0] FREQ_STEP_KHZ = 11'h0FA;
  localparam int NV_W = 18;
  localparam logic [3:0] TMO_NONE = 4'hF;
  localparam logic [3:0] TMO_DEF = 4'hF;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LF = 8'h66;
  localparam logic [7:0] CH_HEX_OFS = 8'h0A;

  typedef enum logic [3:0] {
    RSIC_CMD_RAIL_RANGE = 4'h0, RSIC_CMD_ATTEN = 4'h1, RSIC_CMD_SECOND_RANGE = 4'h2,
    RSIC_CMD_SET_FREQ = 4'h3, RSIC_CMD_PF_RESET = 4'h4, RSIC_CMD_LOAD_DEF = 4'h5,
    RSIC_CMD_PWT = 4'h6, RSIC_CMD_ALG = 4'h7, RSIC_CMD_TMO = 4'h8,
    RSIC_CMD_INVERT = 4'h9, RSIC_CMD_RF_OFF = 4'hA, RSIC_CMD_RF_ON = 4'hB,
    RSIC_CMD_RF_BY_INPUT = 4'hC, RSIC_CMD_READER_RESET = 4'hD
  } rsic_cmd_t;

  typedef enum logic [2:0] {
    RSIC_RSP_NONE = 3'h0, RSIC_RSP_DONE = 3'h1, RSIC_RSP_ERROR = 3'h2,
    RSIC_RSP_FREQ_ERR = 3'h3, RSIC_RSP_INPUT_RPT = 3'h4
  } rsic_rsp_t;

  typedef enum logic [1:0] {
    RSIC_ALG_TMO_ONLY = 2'h0, RSIC_ALG_TMO_TAG = 2'h1, RSIC_ALG_TMO_PRES = 2'h2
  } rsic_alg_t;

  typedef enum logic [1:0] {
    RSIC_RFM_OFF = 2'h0, RSIC_RFM_ON = 2'h1, RSIC_RFM_INPUT = 2'h2
  } rsic_rfm_t;

  typedef struct packed {
    logic [1:0] pres_s1;
    logic [1:0] pres_s2;
    logic [1:0] pres_q;
    logic [4:0] rail_rng;
    logic [4:0] sec_rng;
    logic [3:0] atten;
    logic pwt_en;
    rsic_alg_t alg;
    logic [3:0] tmo;
    logic inv;
    rsic_rfm_t rfm;
    logic rf_on;
    logic tag_seen;
    logic pf;
    logic startup;
    logic pend_ferr;
    logic pend_rpt;
    logic nv_we;
    logic [NV_W-1:0] nv_wd;
    logic [19:0] khz;
    rsic_rsp_t rsp;
  } rsic_state_t;

  localparam logic [3:0] DEF_ALG_UNUSED = 4'h0;

  function automatic logic [9:0] tmo_ms(input logic [3:0] d);
    logic [9:0] t;
    t = 10'h000;
    case (d)
      4'h1: t = 10'h004;
      4'h2: t = 10'h008;
      4'h3: t = 10'h00C;
      4'h4: t = 10'h014;
      4'h5: t = 10'h018;
      4'h6: t = 10'h020;
      4'h7: t = 10'h030;
      4'h8: t = 10'h03C;
      4'h9: t = 10'h05C;
      4'hA: t = 10'h098;
      4'hB: t = 10'h12C;
      4'hC: t = 10'h1C4;
      4'hD: t = 10'h258;
      4'hE: t = 10'h2F0;
      default: t = 10'h000;
    endcase
    return t;
  endfunction
endpackage

/* logic/rsic_fchk.sv */
`timescale 1ns/10ps
// stored word is the code beside its complement, so a torn or flipped word shows
module rsic_fchk import rsic_pkg::*; (
  input wire logic [NV_W-1:0] nv_word,
  output logic freq_ok,
  output logic [8:0] code
);
  always_comb begin
    code = nv_word[8:0];
    freq_ok = (nv_word[17:9] == ~nv_word[8:0]) && (nv_word[8:0] <= FREQ_MAX);
  end
endmodule // rsic_fchk

/* logic/rsic_tmo.sv */
`timescale 1ns/10ps
// millisecond prescaler keeps the table counter narrow
module rsic_tmo import rsic_pkg::*; #(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [3:0] digit,
  output logic expired
);
  typedef struct packed {
    logic [31:0] pre;
    logic [9:0] ms;
  } rsic_tmo_state_t;
  rsic_tmo_state_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    if (!resetn || !run) begin
      r_next = '0;
    end else if (r_reg.pre == 32'(TICK_CYC_P - 1)) begin
      r_next.pre = '0;
      if (r_reg.ms != 10'h3FF) begin
        r_next.ms = r_reg.ms + 10'h001;
      end
    end else begin
      r_next.pre = r_reg.pre + 32'h0000_0001;
    end
    expired = run && (digit != TMO_NONE) && (r_reg.ms >= tmo_ms(digit));
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end
endmodule // rsic_tmo

/* logic/rsic_top.sv */
`timescale 1ns/10ps
// Summary of operation
// - rail tag range code 00..1F, larger is longer, defaults to 1F
// - second protocol range code 00..1F, larger is longer, defaults to 1F
// - attenuation code 00..0A, one dB per step, defaults to zero
// - frequency code 000..118 maps to 860 MHz plus 250 kHz per step
// - a set frequency is written to non-volatile storage and survives power loss
// - corrupted stored frequency disables RF and reports invalid frequency error
// - error repeats at power-up and every RF enable attempt until rewritten
// - power-fail flag is 1 after power returns, cleared by flag reset
// - load defaults restores all settings but frequency, always answers done
// - optional report when presence ends without any valid tag; off by default
// - multiport mode suppresses presence-without-tag reports
// - input RF turns off by timeout, timeout or tag, or timeout or presence lost
// - timeout digits map to 0..752 ms; F means no timeout, default
// - outside multiport mode, with no timeout, RF turns off right after any valid tag
// - timeout digit accepts either letter case; non-hex character gets error
// - multiport mode ignores the timeout selection
// - input inversion swaps open and closed on presence inputs; off by default
// - in RF-by-input control, presence on first input switches RF on
module rsic_top import rsic_pkg::*; #(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_OP,
  input wire logic [11:0] CMD_ARG,
  input wire logic [1:0] PRESENCE_IN,
  input wire logic TAG_VALID,
  input wire logic MULTIPORT_MODE,
  input wire logic [NV_W-1:0] NV_RD_DATA,
  output logic NV_WR_EN,
  output logic [NV_W-1:0] NV_WR_DATA,
  output logic RSP_VALID,
  output logic [2:0] RSP_CODE,
  output logic RF_ON,
  output logic [19:0] RF_FREQ_KHZ,
  output logic [4:0] RAIL_RANGE,
  output logic [4:0] SECOND_RANGE,
  output logic [3:0] TX_ATTEN_DB,
  output logic POWER_FAIL,
  output logic [1:0] PRESENCE
);
  rsic_state_t r_reg, r_next;
  logic freq_ok;
  logic [8:0] freq_code;
  logic tmo_exp;
  logic [3:0] tmo_eff;
  logic [1:0] pres;
  logic rise, fall, off_cond;
  rsic_rsp_t cmd_rsp;
  logic set_ferr, set_rpt;
  logic [4:0] hex_val;

  // returns {valid, value} for an ascii hex character
  function automatic logic [4:0] hex_char(input logic [7:0] c);
    logic [4:0] h;
    h = 5'h00;
    if (c >= CH_0 && c <= CH_9) begin
      h = {1'b1, 4'(c - CH_0)};
    end else if (c >= CH_UA && c <= CH_UF) begin
      h = {1'b1, 4'(c - CH_UA + CH_HEX_OFS)};
    end else if (c >= CH_LA && c <= CH_LF) begin
      h = {1'b1, 4'(c - CH_LA + CH_HEX_OFS)};
    end
    return h;
  endfunction

  rsic_fchk u_fchk (
    .nv_word(NV_RD_DATA),
    .freq_ok(freq_ok),
    .code(freq_code)
  );

  // multiport forces the never-expiring selection
  assign tmo_eff = MULTIPORT_MODE ? TMO_NONE : r_reg.tmo;

  rsic_tmo #(.TICK_CYC_P(TICK_CYC_P)) u_tmo (
    .clk(CLK),
    .resetn(RESETN),
    .run(r_reg.rf_on && r_reg.rfm == RSIC_RFM_INPUT),
    .digit(tmo_eff),
    .expired(tmo_exp)
  );

  always_comb begin
    r_next = r_reg;
    r_next.nv_we = 1'b0;
    r_next.rsp = RSIC_RSP_NONE;
    cmd_rsp = RSIC_RSP_NONE;
    set_ferr = 1'b0;
    set_rpt = 1'b0;
    hex_val = hex_char(CMD_ARG[7:0]);
    r_next.pres_s1 = PRESENCE_IN;
    r_next.pres_s2 = r_reg.pres_s1;
    pres = r_reg.pres_s2 ^ {2{r_reg.inv}};
    r_next.pres_q = pres;
    rise = pres[0] && !r_reg.pres_q[0];
    fall = !pres[0] && r_reg.pres_q[0];
    r_next.startup = 1'b0;
    if (r_reg.startup && !freq_ok) begin
      set_ferr = 1'b1;
    end

    // presence episode bookkeeping for the no-tag report
    if (rise) begin
      r_next.tag_seen = TAG_VALID;
    end else if (TAG_VALID) begin
      r_next.tag_seen = 1'b1;
    end
    if (fall && !r_reg.tag_seen && !TAG_VALID && r_reg.pwt_en && !MULTIPORT_MODE) begin
      set_rpt = 1'b1;
    end

    off_cond = tmo_exp;
    if (r_reg.alg == RSIC_ALG_TMO_TAG && TAG_VALID) begin
      off_cond = 1'b1;
    end
    if (r_reg.alg == RSIC_ALG_TMO_PRES && !pres[0]) begin
      off_cond = 1'b1;
    end
    if (tmo_eff == TMO_NONE && !MULTIPORT_MODE && TAG_VALID) begin
      off_cond = 1'b1;
    end
    if (r_reg.rfm == RSIC_RFM_INPUT) begin
      if (r_reg.rf_on && off_cond) begin
        r_next.rf_on = 1'b0;
      end else if (!r_reg.rf_on && rise) begin
        if (freq_ok) begin
          r_next.rf_on = 1'b1;
        end else begin
          set_ferr = 1'b1;
        end
      end
    end

    if (CMD_VALID) begin
      cmd_rsp = RSIC_RSP_ERROR;
      unique case (rsic_cmd_t'(CMD_OP))
        RSIC_CMD_RAIL_RANGE: if (CMD_ARG <= 12'(RANGE_MAX)) begin
          r_next.rail_rng = CMD_ARG[4:0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_SECOND_RANGE: if (CMD_ARG <= 12'(RANGE_MAX)) begin
          r_next.sec_rng = CMD_ARG[4:0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_ATTEN: if (CMD_ARG <= 12'(ATTEN_MAX)) begin
          r_next.atten = CMD_ARG[3:0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_SET_FREQ: if (CMD_ARG <= 12'(FREQ_MAX)) begin
          r_next.nv_we = 1'b1;
          r_next.nv_wd = {~CMD_ARG[8:0], CMD_ARG[8:0]};
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_PF_RESET, RSIC_CMD_READER_RESET: begin
          r_next.pf = 1'b0;
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_LOAD_DEF: begin
          // frequency lives in storage and is left alone
          r_next.rail_rng = RANGE_DEF;
          r_next.sec_rng = RANGE_DEF;
          r_next.atten = ATTEN_DEF;
          r_next.pwt_en = 1'b0;
          r_next.alg = RSIC_ALG_TMO_PRES;
          r_next.tmo = TMO_DEF;
          r_next.inv = 1'b0;
          r_next.rfm = RSIC_RFM_INPUT;
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_PWT: if (CMD_ARG <= 12'h001) begin
          r_next.pwt_en = CMD_ARG[0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_ALG: if (CMD_ARG <= 12'(RSIC_ALG_TMO_PRES)) begin
          r_next.alg = rsic_alg_t'(CMD_ARG[1:0]);
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_TMO: if (hex_val[4] && CMD_ARG[11:8] == 4'h0) begin
          r_next.tmo = hex_val[3:0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_INVERT: if (CMD_ARG <= 12'h001) begin
          r_next.inv = CMD_ARG[0];
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_RF_OFF: begin
          r_next.rfm = RSIC_RFM_OFF;
          r_next.rf_on = 1'b0;
          cmd_rsp = RSIC_RSP_DONE;
        end
        RSIC_CMD_RF_ON: if (freq_ok) begin
          r_next.rfm = RSIC_RFM_ON;
          r_next.rf_on = 1'b1;
          cmd_rsp = RSIC_RSP_DONE;
        end else begin
          cmd_rsp = RSIC_RSP_FREQ_ERR;
        end
        RSIC_CMD_RF_BY_INPUT: begin
          r_next.rfm = RSIC_RFM_INPUT;
          r_next.rf_on = 1'b0;
          cmd_rsp = RSIC_RSP_DONE;
        end
        default: cmd_rsp = RSIC_RSP_ERROR;
      endcase
    end

    // a bad stored word wins over every enable path
    if (!freq_ok) begin
      if (r_reg.rf_on) begin
        set_ferr = 1'b1;
      end
      r_next.rf_on = 1'b0;
    end

    // command answers first; pending reports wait, and a new event wins over the clear
    r_next.pend_ferr = r_reg.pend_ferr | set_ferr;
    r_next.pend_rpt = r_reg.pend_rpt | set_rpt;
    if (cmd_rsp != RSIC_RSP_NONE) begin
      r_next.rsp = cmd_rsp;
    end else if (r_reg.pend_ferr) begin
      r_next.rsp = RSIC_RSP_FREQ_ERR;
      r_next.pend_ferr = set_ferr;
    end else if (r_reg.pend_rpt) begin
      r_next.rsp = RSIC_RSP_INPUT_RPT;
      r_next.pend_rpt = set_rpt;
    end
    // widen before the product so the top code cannot wrap
    r_next.khz = FREQ_BASE_KHZ + 20'(freq_code) * 20'(FREQ_STEP_KHZ);

    if (!RESETN) begin
      r_next = '0;
      r_next.rail_rng = RANGE_DEF;
      r_next.sec_rng = RANGE_DEF;
      r_next.atten = ATTEN_DEF;
      r_next.alg = RSIC_ALG_TMO_PRES;
      r_next.tmo = TMO_DEF;
      r_next.rfm = RSIC_RFM_INPUT;
      r_next.pf = 1'b1;
      r_next.startup = 1'b1;
      r_next.khz = FREQ_BASE_KHZ;
    end
  end

  always_ff @(posedge CLK) begin
    r_reg <= r_next;
  end

  assign NV_WR_EN = r_reg.nv_we;
  assign NV_WR_DATA = r_reg.nv_wd;
  assign RSP_VALID = r_reg.rsp != RSIC_RSP_NONE;
  assign RSP_CODE = r_reg.rsp;
  assign RF_ON = r_reg.rf_on;
  assign RF_FREQ_KHZ = r_reg.khz;
  assign RAIL_RANGE = r_reg.rail_rng;
  assign SECOND_RANGE = r_reg.sec_rng;
  assign TX_ATTEN_DB = r_reg.atten;
  assign POWER_FAIL = r_reg.pf;
  assign PRESENCE = r_reg.pres_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_rail_ok;
    CMD_VALID && CMD_OP == RSIC_CMD_RAIL_RANGE && CMD_ARG <= 12'h001F;
  endsequence
  sequence s_input_arm;
    r_reg.rfm == RSIC_RFM_INPUT && !r_reg.rf_on && rise && freq_ok && !CMD_VALID;
  endsequence
  sequence s_zero_tmo;
    RF_ON && r_reg.rfm == RSIC_RFM_INPUT && r_reg.tmo == 4'h0 && !MULTIPORT_MODE && !CMD_VALID;
  endsequence

  a_rail_range_set: assert property (s_rail_ok |=> RAIL_RANGE == $past(CMD_ARG[4:0]))
    else $error("rail range not taken");
  a_second_range_bad: assert property (CMD_VALID && CMD_OP == RSIC_CMD_SECOND_RANGE
    && CMD_ARG > 12'h001F |=> $stable(SECOND_RANGE) && RSP_CODE == RSIC_RSP_ERROR)
    else $error("bad second range accepted");
  a_atten_bad: assert property (CMD_VALID && CMD_OP == RSIC_CMD_ATTEN
    && CMD_ARG > 12'h000A |=> $stable(TX_ATTEN_DB))
    else $error("bad attenuation accepted");
  a_freq_store: assert property (CMD_VALID && CMD_OP == RSIC_CMD_SET_FREQ
    && CMD_ARG <= 12'h0118 |=> NV_WR_EN && NV_WR_DATA[8:0] == $past(CMD_ARG[8:0]))
    else $error("frequency not written to storage");
  a_freq_bad_off: assert property (!freq_ok |=> !RF_ON)
    else $error("rf on with corrupt frequency");
  a_pf_clear: assert property (CMD_VALID && CMD_OP == RSIC_CMD_PF_RESET |=> !POWER_FAIL)
    else $error("power fail flag not cleared");
  a_input_rf_on: assert property (s_input_arm |=> RF_ON)
    else $error("presence did not switch rf on");
  a_zero_tmo_off: assert property (s_zero_tmo |-> ##[1:2] !RF_ON)
    else $error("zero timeout left rf on");
  a_tmo_char_err: assert property (CMD_VALID && CMD_OP == RSIC_CMD_TMO && !hex_val[4]
    |=> RSP_VALID && RSP_CODE == RSIC_RSP_ERROR)
    else $error("bad timeout digit not refused");
  // a back-to-back inversion or defaults command would retarget the checked cycle
  a_invert_done: assert property ((CMD_VALID && CMD_OP == RSIC_CMD_INVERT
    && CMD_ARG <= 12'h0001) ##1 !(CMD_VALID && (CMD_OP == RSIC_CMD_INVERT
    || CMD_OP == RSIC_CMD_LOAD_DEF)) |-> RSP_CODE == RSIC_RSP_DONE ##2 PRESENCE == ($past(
    PRESENCE_IN, 3) ^ {2{$past(CMD_ARG[0], 3)}}))
    else $error("inversion not applied");
endmodule // rsic_top

/* sim/rsic_nv_model.sv */
`timescale 1ns/10ps
// word survives bench resets, as storage would across power loss
module rsic_nv_model import rsic_pkg::*; (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [NV_W-1:0] wr_data,
  input wire logic corrupt,
  output logic [NV_W-1:0] rd_data
);
  logic [NV_W-1:0] mem_reg;

  initial mem_reg = {~9'h0D0, 9'h0D0};

  // one flipped bit breaks the code and complement pairing
  always @(posedge clk) begin
    if (wr_en) begin
      mem_reg <= wr_data;
    end else if (corrupt) begin
      mem_reg <= mem_reg ^ 18'h0_0001;
    end
  end

  assign rd_data = mem_reg;
endmodule // rsic_nv_model

/* sim/rsic_top_test.sv */
`timescale 1ns/10ps
module rsic_top_test import rsic_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [11:0] cmd_arg = 12'h000;
  logic [1:0] pres_in = 2'h0;
  logic tag = 1'b0;
  logic mp = 1'b0;
  logic corrupt = 1'b0;
  logic [NV_W-1:0] nv_rd;
  logic [NV_W-1:0] nv_wd;
  logic nv_we;
  logic rsp_v;
  logic rf_on;
  logic pf;
  logic [2:0] rsp_c;
  logic [19:0] khz;
  logic [4:0] rail;
  logic [4:0] sec;
  logic [3:0] att;
  logic [1:0] pres;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  // short millisecond tick keeps the longest timed case near 600 cycles
  rsic_top #(.TICK_CYC_P(4)) dut (
    .CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ARG(cmd_arg), .PRESENCE_IN(pres_in), .TAG_VALID(tag),
    .MULTIPORT_MODE(mp), .NV_RD_DATA(nv_rd), .NV_WR_EN(nv_we),
    .NV_WR_DATA(nv_wd), .RSP_VALID(rsp_v), .RSP_CODE(rsp_c), .RF_ON(rf_on),
    .RF_FREQ_KHZ(khz), .RAIL_RANGE(rail), .SECOND_RANGE(sec),
    .TX_ATTEN_DB(att), .POWER_FAIL(pf), .PRESENCE(pres)
  );

  rsic_nv_model nv (
    .clk(clk), .wr_en(nv_we), .wr_data(nv_wd), .corrupt(corrupt), .rd_data(nv_rd)
  );

  always #12.5 clk = ~clk;

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(logic [3:0] op, logic [11:0] arg, logic [2:0] e);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= arg;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("rsp valid", 1'b1, rsp_v);
    chk("rsp code", e, rsp_c);
  endtask

  task automatic do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic pin(logic [1:0] v);
    @(posedge clk);
    pres_in <= v;
  endtask

  task automatic pulse_tag;
    @(posedge clk);
    tag <= 1'b1;
    @(posedge clk);
    tag <= 1'b0;
  endtask

  task automatic settle(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_rf(logic v, int lim, output int n);
    n = 0;
    #1;
    while (rf_on !== v && n < lim) begin
      settle(1);
      n++;
    end
    chk("rf on", v, rf_on);
  endtask

  task automatic wait_rsp(logic [2:0] e, int lim);
    int i;
    i = 0;
    #1;
    while (rsp_v !== 1'b1 && i < lim) begin
      settle(1);
      i++;
    end
    chk("report", e, (rsp_v === 1'b1) ? rsp_c : 3'h0);
  endtask

  task automatic no_rsp(int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      settle(1);
      seen |= rsp_v;
    end
    chk("quiet", 20'h0_0000, {19'h0_0000, seen});
  endtask

  task automatic t_reset;
    settle(3);
    chk("rail", 5'h1F, rail);
    chk("second", 5'h1F, sec);
    chk("atten", 4'h0, att);
    chk("pf", 1'b1, pf);
    chk("rf", 1'b0, rf_on);
    chk("presence", 2'b00, pres);
    chk("khz", 20'hD_EA80, khz);
    cmd(4'h4, 12'h000, 3'h1);
    chk("pf", 1'b0, pf);
  endtask

  task automatic t_limits;
    cmd(4'h0, 12'h000, 3'h1);
    chk("rail", 5'h00, rail);
    cmd(4'h0, 12'h020, 3'h2);
    chk("rail", 5'h00, rail);
    cmd(4'h0, 12'h01F, 3'h1);
    chk("rail", 5'h1F, rail);
    cmd(4'h2, 12'h000, 3'h1);
    chk("second", 5'h00, sec);
    cmd(4'h2, 12'h020, 3'h2);
    cmd(4'h1, 12'h00A, 3'h1);
    chk("atten", 4'hA, att);
    cmd(4'h1, 12'h00B, 3'h2);
    chk("atten", 4'hA, att);
    cmd(4'hE, 12'h000, 3'h2);
    cmd(4'h0, 12'h005, 3'h1);
    cmd(4'h5, 12'h000, 3'h1);
    chk("rail", 5'h1F, rail);
    chk("second", 5'h1F, sec);
    chk("atten", 4'h0, att);
    chk("khz", 20'hD_EA80, khz);
  endtask

  task automatic t_freq;
    cmd(4'h3, 12'h118, 3'h1);
    chk("nv we", 1'b1, nv_we);
    chk("nv data", {2'b00, ~9'h118, 9'h118}, {2'b00, nv_wd});
    cmd(4'h3, 12'h119, 3'h2);
    chk("nv we", 1'b0, nv_we);
    settle(2);
    chk("khz", 20'hE_30D0, khz);
    do_reset();
    settle(3);
    chk("khz", 20'hE_30D0, khz);
    chk("pf", 1'b1, pf);
    cmd(4'hD, 12'h000, 3'h1);
    chk("pf", 1'b0, pf);
  endtask

  task automatic t_off;
    int n;
    cmd(4'hC, 12'h000, 3'h1);
    cmd(4'h8, 12'h067, 3'h2);
    cmd(4'h7, 12'h003, 3'h2);
    cmd(4'h7, 12'h001, 3'h1);
    cmd(4'h8, 12'h065, 3'h1);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    chk("rf delay", 20'h0_0003, 20'(n));
    pulse_tag();
    wait_rf(1'b0, 3, n);
    pin(2'b00);
    cmd(4'h7, 12'h002, 3'h1);
    cmd(4'h8, 12'h046, 3'h1);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    pulse_tag();
    wait_rf(1'b0, 3, n);
    pin(2'b00);
    settle(4);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    pin(2'b00);
    wait_rf(1'b0, 6, n);
    cmd(4'h7, 12'h000, 3'h1);
    cmd(4'h8, 12'h061, 3'h1);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    wait_rf(1'b0, 700, n);
    chk("timeout", 1'b1, n >= 11'h25F && n <= 11'h263);
    pin(2'b00);
  endtask

  task automatic t_mp;
    int n;
    cmd(4'h6, 12'h002, 3'h2);
    cmd(4'h6, 12'h001, 3'h1);
    cmd(4'h7, 12'h002, 3'h1);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    pin(2'b00);
    wait_rsp(3'h4, 8);
    @(posedge clk);
    mp <= 1'b1;
    cmd(4'h8, 12'h030, 3'h1);
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    settle(8);
    chk("rf held", 1'b1, rf_on);
    pin(2'b00);
    no_rsp(10);
    @(posedge clk);
    mp <= 1'b0;
    pin(2'b01);
    wait_rf(1'b1, 8, n);
    wait_rf(1'b0, 3, n);
    pin(2'b00);
    wait_rsp(3'h4, 8);
    cmd(4'h6, 12'h000, 3'h1);
  endtask

  task automatic t_corrupt;
    @(posedge clk);
    corrupt <= 1'b1;
    @(posedge clk);
    corrupt <= 1'b0;
    cmd(4'hB, 12'h000, 3'h3);
    chk("rf", 1'b0, rf_on);
    cmd(4'hC, 12'h000, 3'h1);
    pin(2'b01);
    wait_rsp(3'h3, 8);
    pin(2'b00);
    do_reset();
    wait_rsp(3'h3, 6);
    cmd(4'h3, 12'h0D0, 3'h1);
    settle(2);
    cmd(4'hB, 12'h000, 3'h1);
    chk("rf", 1'b1, rf_on);
    cmd(4'hA, 12'h000, 3'h1);
    chk("rf", 1'b0, rf_on);
  endtask

  task automatic t_invert;
    cmd(4'h9, 12'h002, 3'h2);
    cmd(4'h9, 12'h001, 3'h1);
    settle(4);
    chk("presence", 2'b11, pres);
    cmd(4'h9, 12'h000, 3'h1);
    settle(4);
    chk("presence", 2'b00, pres);
  endtask

  initial begin
    do_reset();
    t_reset();
    t_limits();
    t_freq();
    t_off();
    t_mp();
    t_corrupt();
    t_invert();
    close_out();
  end
endmodule // rsic_top_test
